// [hdl/cts_map.svh]
// Register map, field codes, sizes and reset values of the trace sequencer
`ifndef CTS_MAP_SVH
`define CTS_MAP_SVH
`define CTS_WORDS 10'h203
`define CTS_LAST_ADDR 10'h202
`define CTS_TRACE_LAST 9'h1ff
`define CTS_DELAY_MAX 16'hffff
`define CTS_TOP_LEVEL 4'hf
`define CTS_DELAY_RST 16'h0001
`define CTS_COND_RST 20'h02222
// Avalon word addresses
`define CTS_R_CTRL 5'h00
`define CTS_R_LSEL 5'h01
`define CTS_R_DELAY 5'h02
`define CTS_R_COND 5'h03
`define CTS_R_PVLO 5'h04
`define CTS_R_PVHI 5'h05
`define CTS_R_PMLO 5'h06
`define CTS_R_PMHI 5'h07
`define CTS_R_SVLO 5'h08
`define CTS_R_SVHI 5'h09
`define CTS_R_SMLO 5'h0a
`define CTS_R_SMHI 5'h0b
`define CTS_R_FIRST 5'h0c
`define CTS_R_COUNT 5'h0d
`define CTS_R_MADDR 5'h0e
`define CTS_R_MLO 5'h0f
`define CTS_R_MHI 5'h10
`define CTS_R_WPTR 5'h11
// Control register bits
`define CTS_C_ARM 0
`define CTS_C_ADV 1
`define CTS_C_STOP 2
`define CTS_C_LOADB 3
`define CTS_C_SRCH 4
`define CTS_C_CMP 5
`define CTS_C_NEXT 6
`define CTS_C_MSEL 7
// Condition codes
`define CTS_K_MATCH 4'h0
`define CTS_K_ALWAYS 4'h1
`define CTS_K_NEVER 4'h2
`define CTS_K_GT 4'h3
`define CTS_K_LT 4'h4
`define CTS_K_EQ 4'h5
`define CTS_K_GE 4'h6
`define CTS_K_LE 4'h7
`define CTS_K_NE 4'h8
`endif

// [hdl/cts_pkg.sv]
// Types shared by the trace sequencer and its memories
`default_nettype none
package cts_pkg;
  typedef struct packed {
    logic valid;
    logic [47:0] data;
  } cts_smp_t;
  typedef struct packed {
    logic [3:0] lvl;
    logic [47:0] data;
  } cts_word_t;
  typedef struct packed {
    logic we;
    logic [9:0] waddr;
    cts_word_t wdata;
    logic [9:0] raddr;
  } cts_mreq_t;
  typedef enum logic [2:0] {
    CTS_IDLE, CTS_FLUSH, CTS_REC, CTS_COPY, CTS_LOADB, CTS_SRCH, CTS_CMP, CTS_NEXT
  } cts_state_t;
endpackage
`default_nettype wire

// [hdl/cts_mem.sv]
// One 515-word trace memory with registered read data
`include "cts_map.svh"
`default_nettype none
module cts_mem (
  // Clock
  input wire logic core_clk,
  // Access
  input wire cts_pkg::cts_mreq_t req,
  output cts_pkg::cts_word_t rdata
);
  import cts_pkg::*;
  cts_word_t mem [0:`CTS_WORDS-1];

  // No reset: contents are flushed or overwritten by the engine
  always_ff @(posedge core_clk) begin
    if (req.we) begin
      mem[req.waddr] <= req.wdata;
    end
    rdata <= mem[req.raddr];
  end
endmodule
`default_nettype wire

// [hdl/cts_top.sv]
// Conditional trace sequencer with main, display and reference memories
`include "cts_map.svh"
`default_nettype none
// Operation
// - Sixteen levels, moving freely between them.
// - Stop beats jump, jump beats advance.
// - Per-level delay value 1 to FFFF.
// - Counter counts samples or advance matches.
// - Counter restarts on every level entry.
// - Nine stop conditions; stop ends recording.
// - Stopping sample still stored if traced.
// - Jump to target level; self-jump restarts count.
// - Jumping sample still stored if traced.
// - Advance to next level, sample still stored if traced.
// - 48-bit patterns with per-bit don't care.
// - Independent trace condition stores into main memory.
// - Words are level tag plus 48 data.
// - 515 words, 512 traced, 3 reserved.
// - Copy main to display; reference loadable.
// - Search flags matches, first, last, count.
// - Compare marks differences, step through them.
// - Sample strobe moves samples into memory.
// - External advance forces next level.
// - Arming resets control, flushes main memory.
module cts_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Samples from the input section
  input wire cts_pkg::cts_smp_t smp,
  // Status
  output logic [3:0] level_out,
  output logic armed_out
);
  import cts_pkg::*;

  function automatic logic pmatch(input logic [47:0] v, input logic [47:0] m,
                                  input logic [47:0] d);
    pmatch = ~|((v ^ d) & m);
  endfunction

  function automatic logic cond_ok(input logic [3:0] k, input logic hit,
                                   input logic [15:0] c, input logic [15:0] dl);
    case (k)
      `CTS_K_MATCH: cond_ok = hit;
      `CTS_K_ALWAYS: cond_ok = 1'b1;
      `CTS_K_NEVER: cond_ok = 1'b0;
      `CTS_K_GT: cond_ok = hit && c > dl;
      `CTS_K_LT: cond_ok = hit && c < dl;
      `CTS_K_EQ: cond_ok = hit && c == dl;
      `CTS_K_GE: cond_ok = hit && c >= dl;
      `CTS_K_LE: cond_ok = hit && c <= dl;
      `CTS_K_NE: cond_ok = hit && c != dl;
      default: cond_ok = 1'b0;
    endcase
  endfunction

  cts_state_t st;
  logic [15:0] dly [16];
  logic cmode [16];
  logic [19:0] cnd [16];
  logic [47:0] pval [4][16];
  logic [47:0] pmsk [4][16];
  logic [3:0] lsel;
  logic [1:0] psel;
  logic [47:0] sv, sm;
  logic msel;
  logic [31:0] mlo;
  logic [9:0] maddr, sa, pa;
  logic sp;
  logic [3:0] lvl;
  logic [15:0] cnt;
  logic [8:0] wp;
  logic wrapped;
  logic [514:0] flg;
  logic [9:0] first, last, mcount;
  cts_mreq_t m_req, a_req, b_req;
  cts_word_t m_rd, a_rd, b_rd, srd;

  // Bus handshake: every access answers one cycle after it is seen
  logic req, wr;
  logic [31:0] wctl;
  assign req = avs_read | avs_write;
  assign wr = avs_write & ~avs_waitrequest;
  assign wctl = (wr && avs_address == `CTS_R_CTRL) ? avs_writedata : 32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  logic [31:0] rd_mux;
  logic busy;
  assign busy = st != CTS_IDLE && st != CTS_REC && st != CTS_FLUSH;
  assign srd = msel ? b_rd : a_rd;
  always_comb begin
    unique case (avs_address)
      `CTS_R_CTRL: rd_mux = {20'h0, lvl, msel, 5'h0, busy, armed_out};
      `CTS_R_LSEL: rd_mux = {26'h0, psel, lsel};
      `CTS_R_DELAY: rd_mux = {15'h0, cmode[lsel], dly[lsel]};
      `CTS_R_COND: rd_mux = {12'h0, cnd[lsel]};
      `CTS_R_PVLO: rd_mux = pval[psel][lsel][31:0];
      `CTS_R_PVHI: rd_mux = {16'h0, pval[psel][lsel][47:32]};
      `CTS_R_PMLO: rd_mux = pmsk[psel][lsel][31:0];
      `CTS_R_PMHI: rd_mux = {16'h0, pmsk[psel][lsel][47:32]};
      `CTS_R_SVLO: rd_mux = sv[31:0];
      `CTS_R_SVHI: rd_mux = {16'h0, sv[47:32]};
      `CTS_R_SMLO: rd_mux = sm[31:0];
      `CTS_R_SMHI: rd_mux = {16'h0, sm[47:32]};
      `CTS_R_FIRST: rd_mux = {6'h0, last, 6'h0, first};
      `CTS_R_COUNT: rd_mux = {22'h0, mcount};
      `CTS_R_MADDR: rd_mux = {15'h0, flg[maddr], 6'h0, maddr};
      `CTS_R_MLO: rd_mux = srd.data[31:0];
      `CTS_R_MHI: rd_mux = {12'h0, srd.lvl, srd.data[47:32]};
      `CTS_R_WPTR: rd_mux = {15'h0, wrapped, 7'h0, wp};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        dly[i] <= `CTS_DELAY_RST;
        cmode[i] <= 1'b0;
        cnd[i] <= `CTS_COND_RST;
        for (int j = 0; j < 4; j++) begin
          pval[j][i] <= 48'h0;
          pmsk[j][i] <= 48'h0;
        end
      end
      lsel <= 4'h0;
      psel <= 2'h0;
      sv <= 48'h0;
      sm <= 48'h0;
      msel <= 1'b0;
      mlo <= 32'h0;
    end else if (wr) begin
      unique case (avs_address)
        `CTS_R_CTRL: msel <= avs_writedata[`CTS_C_MSEL];
        `CTS_R_LSEL: {psel, lsel} <= avs_writedata[5:0];
        `CTS_R_DELAY: begin
          // Zero is not a legal delay, keep the old value
          if (avs_writedata[15:0] != 16'h0) begin
            dly[lsel] <= avs_writedata[15:0];
          end
          cmode[lsel] <= avs_writedata[16];
        end
        `CTS_R_COND: cnd[lsel] <= avs_writedata[19:0];
        `CTS_R_PVLO: pval[psel][lsel][31:0] <= avs_writedata;
        `CTS_R_PVHI: pval[psel][lsel][47:32] <= avs_writedata[15:0];
        `CTS_R_PMLO: pmsk[psel][lsel][31:0] <= avs_writedata;
        `CTS_R_PMHI: pmsk[psel][lsel][47:32] <= avs_writedata[15:0];
        `CTS_R_SVLO: sv[31:0] <= avs_writedata;
        `CTS_R_SVHI: sv[47:32] <= avs_writedata[15:0];
        `CTS_R_SMLO: sm[31:0] <= avs_writedata;
        `CTS_R_SMHI: sm[47:32] <= avs_writedata[15:0];
        `CTS_R_MLO: mlo <= avs_writedata;
        default: ;
      endcase
    end
  end

  // Sequencer evaluation for the current sample
  logic go, cm, inc, stop_t, jump_t, adv_t, trc_t;
  logic stop_now, jump_now, adv_now, trc_now;
  logic [3:0] tgt;
  logic [15:0] c_now;
  logic [47:0] d;
  assign d = smp.data;
  assign go = st == CTS_REC && smp.valid;
  assign cm = cmode[lvl];
  assign tgt = cnd[lvl][19:16];
  assign inc = cm ? pmatch(pval[2][lvl], pmsk[2][lvl], d) : 1'b1;
  // Saturates instead of wrapping so a long wait cannot fake a small count
  assign c_now = (!inc || cnt == `CTS_DELAY_MAX) ? cnt : cnt + 16'h0001;
  assign stop_t = cond_ok(cnd[lvl][3:0], pmatch(pval[0][lvl], pmsk[0][lvl], d), c_now, dly[lvl]);
  assign jump_t = cond_ok(cnd[lvl][7:4], pmatch(pval[1][lvl], pmsk[1][lvl], d), c_now, dly[lvl]);
  assign adv_t = cond_ok(cnd[lvl][11:8], pmatch(pval[2][lvl], pmsk[2][lvl], d), c_now, dly[lvl]);
  assign trc_t = cond_ok(cnd[lvl][15:12], pmatch(pval[3][lvl], pmsk[3][lvl], d), c_now, dly[lvl]);
  assign stop_now = go && stop_t;
  assign jump_now = go && !stop_t && jump_t;
  assign adv_now = go && !stop_t && !jump_t && adv_t;
  assign trc_now = go && trc_t;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lvl <= 4'h0;
      cnt <= 16'h0;
    end else if (wctl[`CTS_C_ARM]) begin
      lvl <= 4'h0;
      cnt <= 16'h0;
    end else if (st == CTS_REC && wctl[`CTS_C_ADV]) begin
      if (lvl != `CTS_TOP_LEVEL) begin
        lvl <= lvl + 4'h1;
      end
      cnt <= 16'h0;
    end else if (jump_now) begin
      lvl <= tgt;
      cnt <= 16'h0;
    end else if (adv_now) begin
      // Top level has nowhere to go: re-entered in place
      if (lvl != `CTS_TOP_LEVEL) begin
        lvl <= lvl + 4'h1;
      end
      cnt <= 16'h0;
    end else if (go) begin
      cnt <= c_now;
    end
  end

  // Trace ring pointer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp <= 9'h0;
      wrapped <= 1'b0;
    end else if (wctl[`CTS_C_ARM]) begin
      wp <= 9'h0;
      wrapped <= 1'b0;
    end else if (trc_now) begin
      wp <= wp + 9'h001;
      if (wp == `CTS_TRACE_LAST) begin
        wrapped <= 1'b1;
      end
    end
  end

  // Engine: flush, record, copy, load, search, compare, step
  logic scan_end;
  logic [9:0] nx;
  assign scan_end = sp && pa == `CTS_LAST_ADDR;
  assign nx = maddr + 10'h001;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= CTS_IDLE;
      sa <= 10'h0;
      sp <= 1'b0;
      pa <= 10'h0;
      maddr <= 10'h0;
    end else begin
      sp <= 1'b0;
      if (wctl[`CTS_C_ARM]) begin
        st <= CTS_FLUSH;
        sa <= 10'h0;
      end else begin
        unique case (st)
          CTS_IDLE: begin
            sa <= 10'h0;
            if (wr && avs_address == `CTS_R_MADDR && avs_writedata[9:0] <= `CTS_LAST_ADDR) begin
              maddr <= avs_writedata[9:0];
            end
            if (wctl[`CTS_C_LOADB]) begin
              st <= CTS_LOADB;
            end else if (wctl[`CTS_C_SRCH]) begin
              st <= CTS_SRCH;
            end else if (wctl[`CTS_C_CMP]) begin
              st <= CTS_CMP;
            end else if (wctl[`CTS_C_NEXT] && maddr != `CTS_LAST_ADDR) begin
              st <= CTS_NEXT;
            end
          end
          CTS_FLUSH: begin
            sa <= sa + 10'h001;
            if (sa == `CTS_LAST_ADDR) begin
              st <= CTS_REC;
            end
          end
          CTS_REC: begin
            sa <= 10'h0;
            // Manual stop keeps the display memory as it was
            if (wctl[`CTS_C_STOP]) begin
              st <= CTS_IDLE;
            end else if (stop_now) begin
              st <= CTS_COPY;
            end
          end
          CTS_NEXT: begin
            maddr <= nx;
            if (flg[nx] || nx == `CTS_LAST_ADDR) begin
              st <= CTS_IDLE;
            end
          end
          CTS_COPY, CTS_LOADB, CTS_SRCH, CTS_CMP: begin
            if (sa <= `CTS_LAST_ADDR) begin
              sa <= sa + 10'h001;
              sp <= 1'b1;
              pa <= sa;
            end
            if (scan_end) begin
              st <= CTS_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Search and compare results
  logic hit;
  assign hit = st == CTS_SRCH ? pmatch(sv, sm, srd.data) : a_rd != b_rd;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flg <= '0;
      first <= 10'h0;
      last <= 10'h0;
      mcount <= 10'h0;
    end else if (st == CTS_IDLE && (wctl[`CTS_C_SRCH] || wctl[`CTS_C_CMP])) begin
      flg <= '0;
      first <= 10'h0;
      last <= 10'h0;
      mcount <= 10'h0;
    end else if (sp && (st == CTS_SRCH || st == CTS_CMP) && hit) begin
      flg[pa] <= 1'b1;
      if (mcount == 10'h0) begin
        first <= pa;
      end
      last <= pa;
      mcount <= mcount + 10'h001;
    end
  end

  // Memory ports
  always_comb begin
    m_req = '0;
    a_req = '0;
    b_req = '0;
    m_req.raddr = sa;
    a_req.raddr = st == CTS_IDLE ? maddr : sa;
    b_req.raddr = st == CTS_IDLE ? maddr : sa;
    if (st == CTS_FLUSH) begin
      m_req.we = 1'b1;
      m_req.waddr = sa;
    end else if (trc_now) begin
      // Reserved top words stay zero; traced words stay below them
      m_req.we = 1'b1;
      m_req.waddr = {1'b0, wp};
      m_req.wdata = {lvl, d};
    end
    a_req.we = sp && st == CTS_COPY;
    a_req.waddr = pa;
    a_req.wdata = m_rd;
    if (sp && st == CTS_LOADB) begin
      b_req.we = 1'b1;
      b_req.waddr = pa;
      b_req.wdata = a_rd;
    end else if (st == CTS_IDLE && wr && avs_address == `CTS_R_MHI) begin
      b_req.we = 1'b1;
      b_req.waddr = maddr;
      b_req.wdata = {avs_writedata[19:0], mlo};
    end
  end

  cts_mem u_mem_m (.core_clk(core_clk), .req(m_req), .rdata(m_rd));
  cts_mem u_mem_a (.core_clk(core_clk), .req(a_req), .rdata(a_rd));
  cts_mem u_mem_b (.core_clk(core_clk), .req(b_req), .rdata(b_rd));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_out <= 4'h0;
      armed_out <= 1'b0;
    end else begin
      level_out <= lvl;
      armed_out <= st == CTS_FLUSH || st == CTS_REC;
    end
  end

  arm_init_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wctl[`CTS_C_ARM] |=> lvl == 4'h0 && cnt == 16'h0 && st == CTS_FLUSH)
    else $error("arm did not restart at level zero");
  flush_end_a: assert property (
    @(posedge core_clk) disable iff (rst)
    st == CTS_FLUSH && sa == `CTS_LAST_ADDR && !wctl[`CTS_C_ARM] |=> st == CTS_REC)
    else $error("flush did not end in recording");
  stop_prio_a: assert property (
    @(posedge core_clk) disable iff (rst)
    stop_now && !wctl[`CTS_C_ARM] && !wctl[`CTS_C_STOP] && !wctl[`CTS_C_ADV]
      |=> st == CTS_COPY && lvl == $past(lvl))
    else $error("stop did not win");
  stop_store_a: assert property (
    @(posedge core_clk) disable iff (rst)
    stop_now && trc_t |-> m_req.we && m_req.wdata.lvl == lvl)
    else $error("stopping sample not stored");
  jump_move_a: assert property (
    @(posedge core_clk) disable iff (rst)
    jump_now && !wctl[`CTS_C_ARM] && !wctl[`CTS_C_ADV] |=> lvl == $past(tgt) && cnt == 16'h0)
    else $error("jump went astray");
  adv_move_a: assert property (
    @(posedge core_clk) disable iff (rst)
    adv_now && !wctl[`CTS_C_ARM] && !wctl[`CTS_C_ADV] && lvl != `CTS_TOP_LEVEL
      |=> lvl == $past(lvl) + 4'h1 && cnt == 16'h0)
    else $error("advance went astray");
  ring_wrap_a: assert property (
    @(posedge core_clk) disable iff (rst)
    trc_now && wp == `CTS_TRACE_LAST && !wctl[`CTS_C_ARM] |=> wp == 9'h0 && wrapped)
    else $error("trace ring did not wrap");
  count_step_a: assert property (
    @(posedge core_clk) disable iff (rst)
    go && !stop_t && !jump_t && !adv_t && !cm && cnt != `CTS_DELAY_MAX
      && !wctl[`CTS_C_ARM] && !wctl[`CTS_C_ADV] |=> cnt == $past(cnt) + 16'h0001)
    else $error("sample count did not step");
  copy_done_a: assert property (
    @(posedge core_clk) disable iff (rst)
    scan_end && st == CTS_COPY && !wctl[`CTS_C_ARM] |=> st == CTS_IDLE)
    else $error("copy did not finish");
endmodule
`default_nettype wire

// [verification/cts_src.sv]
// Sample source standing in for the input sample registers
`default_nettype none
module cts_src #(
  parameter logic [15:0] BASE_HI = 16'h5a3c
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pacing from the bench
  input wire logic run,
  input wire logic gap,
  // Samples toward the sequencer
  output var cts_pkg::cts_smp_t smp
);
  import cts_pkg::*;
  logic [15:0] seq;
  logic phase;
  // Slow mode offers a sample every other cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
    end else begin
      phase <= run ? ~phase : 1'b0;
    end
  end
  // Idle data toggles, so a stale word never passes for a sample
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq <= 16'h0000;
      smp <= '0;
    end else if (run && (!gap || phase)) begin
      seq <= seq + 16'h0001;
      smp.valid <= 1'b1;
      smp.data <= {BASE_HI, 16'h0000, seq + 16'h0001};
    end else begin
      seq <= run ? seq : 16'h0000;
      smp.valid <= 1'b0;
      smp.data <= ~smp.data;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_conditional_trace_sequencer.sv]
// Self-checking bench for the conditional trace sequencer
`include "cts_map.svh"
`default_nettype none
module tb_conditional_trace_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import cts_pkg::*;
  localparam logic [15:0] HI = 16'h5a3c;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] level_out;
  logic armed_out;
  logic run = 1'b0;
  logic gap = 1'b0;
  cts_smp_t smp;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] rv;
  logic [31:0] lo;
  logic [31:0] hi;

  cts_top dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .smp(smp),
    .level_out(level_out), .armed_out(armed_out));
  cts_src #(.BASE_HI(HI)) src (.core_clk(core_clk), .rst(rst), .run(run), .gap(gap),
    .smp(smp));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // Held until waitrequest is sampled low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) chk("bus answer", 32'h0, 32'h1);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, `CTS_R_CTRL, 32'h0);
      n++;
    end while (rv[1] !== 1'b0 && n < 1000);
    if (n >= 1000) chk("busy end", 32'h0, 32'h1);
  endtask

  task automatic re_rst();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic set_lvl(input logic [3:0] l, input logic [15:0] dly, input logic [19:0] c);
    bus(1'b1, `CTS_R_LSEL, {28'h0, l});
    bus(1'b1, `CTS_R_DELAY, {16'h0, dly});
    bus(1'b1, `CTS_R_COND, {12'h0, c});
  endtask

  task automatic rd_word(input logic [9:0] a);
    bus(1'b1, `CTS_R_MADDR, {22'h0, a});
    bus(1'b0, `CTS_R_MLO, 32'h0);
    lo = rv;
    bus(1'b0, `CTS_R_MHI, 32'h0);
    hi = rv;
  endtask

  // Arm, let the flush finish, stream samples until the stop and copy end
  task automatic record(input logic slow);
    int n;
    n = 0;
    gap <= slow;
    bus(1'b1, `CTS_R_CTRL, 32'h1);
    repeat (530) @(posedge core_clk);
    chk("armed", 32'h1, {31'h0, armed_out});
    chk("arm level", 32'h0, {28'h0, level_out});
    run <= 1'b1;
    while (armed_out === 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    run <= 1'b0;
    if (n >= 3000) chk("recording end", 32'h0, 32'h1);
    idle();
  endtask

  task automatic t_reset_values();
    bus(1'b0, `CTS_R_CTRL, 32'h0);
    chk("ctrl armed", 32'h0, {31'h0, rv[0]});
    chk("ctrl level", 32'h0, {28'h0, rv[11:8]});
    bus(1'b0, `CTS_R_DELAY, 32'h0);
    chk("delay reset", 32'h1, {15'h0, rv[16:0]});
    bus(1'b0, `CTS_R_COND, 32'h0);
    chk("cond reset", 32'h02222, {12'h0, rv[19:0]});
    bus(1'b0, 5'h1f, 32'h0);
    chk("unmapped", 32'h0, rv);
  endtask

  // Stop on a masked pattern; upper bits are don't care
  task automatic t_stop_match();
    re_rst();
    set_lvl(4'h0, 16'h0001, 20'h01220);
    bus(1'b1, `CTS_R_PVLO, 32'h0000_0003);
    bus(1'b1, `CTS_R_PVHI, 32'h0000_1234);
    bus(1'b1, `CTS_R_PMLO, 32'h0000_ffff);
    record(1'b0);
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("wptr stop", 32'h3, rv & 32'h0001_01ff);
    rd_word(10'h002);
    chk("stop word", 32'h3, lo);
  endtask

  // Jump beats advance, stop beats jump; tags follow the level
  task automatic t_levels();
    logic [3:0] tags [4];
    tags = '{4'h0, 4'h2, 4'h2, 4'h3};
    re_rst();
    set_lvl(4'h0, 16'h0001, 20'h21112);
    set_lvl(4'h2, 16'h0002, 20'h01622);
    set_lvl(4'h3, 16'h0001, 20'h01111);
    record(1'b1);
    bus(1'b0, `CTS_R_CTRL, 32'h0);
    chk("last level", 32'h3, {28'h0, rv[11:8]});
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("wptr levels", 32'h4, rv & 32'h0001_01ff);
    for (int i = 0; i < 4; i++) begin
      rd_word(10'(i));
      chk("word data", {16'h0, 16'(i + 1)}, lo);
      chk("word tag", {12'h0, tags[i], HI}, hi);
    end
  endtask

  task automatic t_search();
    bus(1'b1, `CTS_R_SVHI, {16'h0, HI});
    bus(1'b1, `CTS_R_SMHI, 32'h0000_ffff);
    bus(1'b1, `CTS_R_CTRL, 32'h10);
    idle();
    bus(1'b0, `CTS_R_FIRST, 32'h0);
    chk("first last", 32'h0003_0000, rv & 32'h03ff_03ff);
    bus(1'b0, `CTS_R_COUNT, 32'h0);
    chk("match count", 32'h4, rv & 32'h3ff);
  endtask

  task automatic t_compare();
    bus(1'b1, `CTS_R_CTRL, 32'h08);
    idle();
    bus(1'b1, `CTS_R_CTRL, 32'h20);
    idle();
    bus(1'b0, `CTS_R_COUNT, 32'h0);
    chk("equal count", 32'h0, rv & 32'h3ff);
    bus(1'b1, `CTS_R_CTRL, 32'h80);
    bus(1'b1, `CTS_R_MADDR, 32'h2);
    bus(1'b1, `CTS_R_MLO, 32'h0000_dead);
    bus(1'b1, `CTS_R_MHI, 32'h0);
    bus(1'b1, `CTS_R_CTRL, 32'ha0);
    idle();
    bus(1'b0, `CTS_R_COUNT, 32'h0);
    chk("diff count", 32'h1, rv & 32'h3ff);
    bus(1'b0, `CTS_R_FIRST, 32'h0);
    chk("diff place", 32'h0002_0002, rv & 32'h03ff_03ff);
    bus(1'b1, `CTS_R_MADDR, 32'h0);
    bus(1'b1, `CTS_R_CTRL, 32'hc0);
    idle();
    bus(1'b0, `CTS_R_MADDR, 32'h0);
    chk("step cursor", 32'h0001_0002, rv & 32'h0001_03ff);
  endtask

  // Forced advances, then a fresh arm starts over, then a manual stop
  task automatic t_ext_adv();
    int n;
    n = 0;
    re_rst();
    gap <= 1'b0;
    set_lvl(4'h0, 16'h0001, 20'h01222);
    bus(1'b1, `CTS_R_CTRL, 32'h1);
    repeat (530) @(posedge core_clk);
    // Four samples traced so the rearm has something to flush
    run <= 1'b1;
    repeat (4) @(posedge core_clk);
    run <= 1'b0;
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("traced before arm", 32'h4, rv & 32'h0001_01ff);
    bus(1'b1, `CTS_R_CTRL, 32'h2);
    repeat (3) @(posedge core_clk);
    chk("adv one", 32'h1, {28'h0, level_out});
    bus(1'b1, `CTS_R_CTRL, 32'h2);
    repeat (3) @(posedge core_clk);
    chk("adv two", 32'h2, {28'h0, level_out});
    bus(1'b1, `CTS_R_CTRL, 32'h1);
    repeat (530) @(posedge core_clk);
    chk("rearm level", 32'h0, {28'h0, level_out});
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("rearm wptr", 32'h0, rv & 32'h0001_01ff);
    bus(1'b1, `CTS_R_CTRL, 32'h4);
    while (armed_out === 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("manual stop", 32'h0, {31'h0, armed_out});
  endtask

  // 514 samples into 512 slots: the ring wraps over the oldest words
  task automatic t_wrap();
    re_rst();
    set_lvl(4'h0, 16'h0202, 20'h01226);
    record(1'b0);
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("wrap wptr", 32'h0001_0002, rv & 32'h0001_01ff);
    rd_word(10'h000);
    chk("wrap word0", 32'h0000_0201, lo);
    rd_word(10'h001);
    chk("wrap word1", 32'h0000_0202, lo);
  endtask

  // Count only odd samples, then a self-jump that restarts the count
  task automatic t_count();
    re_rst();
    set_lvl(4'h0, 16'h0002, 20'h01225);
    bus(1'b1, `CTS_R_LSEL, 32'h20);
    bus(1'b1, `CTS_R_DELAY, 32'h0001_0002);
    bus(1'b1, `CTS_R_PVLO, 32'h1);
    bus(1'b1, `CTS_R_PMLO, 32'h1);
    record(1'b0);
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("count mode", 32'h3, rv & 32'h0001_01ff);
    re_rst();
    set_lvl(4'h0, 16'h0002, 20'h05250);
    bus(1'b1, `CTS_R_PVLO, 32'h6);
    bus(1'b1, `CTS_R_PMLO, 32'h0000_ffff);
    record(1'b0);
    bus(1'b0, `CTS_R_WPTR, 32'h0);
    chk("self jump", 32'h3, rv & 32'h0001_01ff);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_values();
    t_stop_match();
    t_levels();
    t_search();
    t_compare();
    t_ext_adv();
    t_wrap();
    t_count();
    stop_test();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    chk("watchdog", 32'h0, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
